// ==== include/plc_pkg.sv ====
package plc_pkg;
	// command codes
	localparam logic [7:0] CMD_CYCLIC   = 8'hD3; // cyclic log setup word
	localparam logic [7:0] CMD_PINS     = 8'hD4; // driver pin setup block
	// pin index parameter
	localparam logic [7:0] IDX_ALL      = 8'hFF; // read back every pin
	localparam logic [7:0] IDX_LIMIT    = 8'h10; // single pin index bound
	localparam logic [7:0] PARAM_LEN    = 8'h01; // write-read parameter size
	// block read lengths
	localparam logic [7:0] LEN_ONE      = 8'h02; // one pin record
	localparam logic [7:0] LEN_ALL      = 8'h20; // all sixteen records
	// block write byte count range
	localparam logic [7:0] WR_CNT_MIN   = 8'h03; // least byte count
	localparam logic [7:0] WR_CNT_MAX   = 8'h21; // largest byte count
	// word write length
	localparam logic [5:0] WORD_BYTES   = 6'h02; // bytes in a word write
	// field positions
	localparam int         CYCLIC_POS   = 0;     // cyclic enable bit
	localparam int         MODE_LSB     = 13;    // operating mode lsb
	// operating mode codes
	localparam logic [2:0] MODE_OFF     = 3'h0;  // pin disabled
	localparam logic [2:0] MODE_OUT     = 3'h1;  // pin is an output
	localparam logic [2:0] MODE_IN      = 3'h2;  // pin is an input
	// reset values
	localparam logic       CYCLIC_RST   = 1'b0;  // cyclic recording off
	localparam logic [15:0] PIN_REC_RST = 16'h0000; // pin disabled

	// one pin record, two bytes, low byte first on the wire
	typedef struct packed {
		logic [2:0]  mode; // operating mode, bits 15:13
		logic [12:0] rest; // filter, reserved and driver fields
	} plc_pin_rec_t;

	// transaction state by command code
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CYC,
		ST_PIN,
		ST_OTHER
	} plc_state_t;
endpackage : plc_pkg

// ==== src/plc_cmd.sv ====
`timescale 1ns/1ps
// Summary of operation
// [RL1] 0xD3 word: bit 0 enables cyclic recording
// [RL2] host sends length 1 then pin index
// [RL3] index 0..15 picks pin, 0xFF all
// [RL4] read returns length 2 or 32 first
// [RL5] host write count runs 3 to 33
// [RL6] records fill consecutive pins from start index
// [RL7] each pin record is two bytes
// [RL8] bits 15:13 give pin operating mode
// [RL9] bad count or overrun write is rejected
// [RL10] reserved cyclic bits read zero, writes ignored
module plc_cmd #(
	parameter int NUM_PINS = 16 // programmable driver pins
) (
	input  wire logic                   ref_clk,   // core clock, 25 MHz
	input  wire logic                   rst_n,     // sync reset, low
	input  wire logic                   txn_start, // command byte taken
	input  wire logic [7:0]             cmd_code,  // command code
	input  wire logic                   wr_valid,  // host data byte
	input  wire logic [7:0]             wr_byte,   // host data value
	input  wire logic                   rd_req,    // host wants a byte
	input  wire logic                   txn_stop,  // stop, commit writes
	output logic                        rd_valid_q, // answer strobe
	output logic [7:0]                  rd_data_q,  // answer byte
	output logic                        cyclic_log_en_q, // cyclic on
	output plc_pkg::plc_pin_rec_t [NUM_PINS-1:0] pin_rec_q, // records
	output logic [NUM_PINS-1:0]         pin_out_en_q, // pin is output
	output logic [NUM_PINS-1:0]         pin_in_en_q,  // pin is input
	output logic                        wr_reject_q   // write refused
);
	////////////////////////////////////////////////////////////////////
	// parameter check
	if (NUM_PINS != 16) begin : g_bad_pins
		$error("plc_cmd: index decode serves exactly 16 pins");
	end

	////////////////////////////////////////////////////////////////////
	// declarations
	plc_pkg::plc_state_t state_q;   // current command
	logic [5:0]          wr_cnt_q;  // data bytes after command code
	logic [5:0]          rd_ptr_q;  // read bytes already answered
	logic                rd_seen_q; // read phase reached
	logic                cyc_new_q; // staged cyclic enable
	logic [7:0]          blk_cnt_q; // block count or parameter length
	logic [7:0]          blk_idx_q; // start or readback index
	logic [7:0]          stage_q [0:31]; // staged record bytes
	logic [8:0]          blk_end;   // one past last pin written
	logic                blk_ok;    // block write is legal
	logic                commit_pin; // apply staged records
	logic                commit_cyc; // apply staged cyclic bit
	logic [7:0]          rd_len;    // readback length byte
	logic [5:0]          rd_off;    // record byte offset
	logic [3:0]          rd_pin;    // pin being read back
	logic [7:0]          rd_next;   // next answer byte

	////////////////////////////////////////////////////////////////////
	// command state
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q <= plc_pkg::ST_IDLE;
		end else if (txn_start) begin
			unique case (cmd_code)
				plc_pkg::CMD_CYCLIC: state_q <= plc_pkg::ST_CYC;
				plc_pkg::CMD_PINS:   state_q <= plc_pkg::ST_PIN;
				default:             state_q <= plc_pkg::ST_OTHER;
			endcase
		end else if (txn_stop) begin
			state_q <= plc_pkg::ST_IDLE;
		end
	end

	// byte counters and read phase flag
	always_ff @(posedge ref_clk) begin
		if (!rst_n || txn_start) begin
			wr_cnt_q  <= 6'h00;
			rd_ptr_q  <= 6'h00;
			rd_seen_q <= 1'b0;
		end else begin
			if (wr_valid && wr_cnt_q != 6'h3F) begin
				wr_cnt_q <= wr_cnt_q + 6'h01; // saturates
			end
			if (rd_req) begin
				rd_seen_q <= 1'b1;
				if (rd_ptr_q != 6'h3F) begin
					rd_ptr_q <= rd_ptr_q + 6'h01;
				end
			end
		end
	end

	// staging of written bytes
	always_ff @(posedge ref_clk) begin
		if (!rst_n || txn_start) begin
			cyc_new_q <= plc_pkg::CYCLIC_RST;
			blk_cnt_q <= 8'h00;
			blk_idx_q <= plc_pkg::IDX_ALL; // bare read shows all pins
		end else if (wr_valid && state_q == plc_pkg::ST_CYC) begin
			if (wr_cnt_q == 6'h00) begin
				cyc_new_q <= wr_byte[plc_pkg::CYCLIC_POS]; // RL10
			end
		end else if (wr_valid && state_q == plc_pkg::ST_PIN) begin
			if (wr_cnt_q == 6'h00) begin
				blk_cnt_q <= wr_byte; // RL2 RL5
			end else if (wr_cnt_q == 6'h01) begin
				blk_idx_q <= wr_byte; // RL3
			end
		end
	end

	// record bytes, low byte of each pin first
	always_ff @(posedge ref_clk) begin
		if (wr_valid && state_q == plc_pkg::ST_PIN &&
				wr_cnt_q >= 6'h02 && wr_cnt_q < 6'h22) begin
			stage_q[5'(wr_cnt_q - 6'h02)] <= wr_byte; // RL7
		end
	end

	////////////////////////////////////////////////////////////////////
	// block write check
	assign blk_end = {1'b0, blk_idx_q} +
		9'((blk_cnt_q - 8'h01) >> 1); // RL6
	assign blk_ok = blk_cnt_q >= plc_pkg::WR_CNT_MIN &&
		blk_cnt_q <= plc_pkg::WR_CNT_MAX && blk_cnt_q[0] &&
		({2'b00, wr_cnt_q} == blk_cnt_q + 8'h01) &&
		blk_idx_q < plc_pkg::IDX_LIMIT &&
		blk_end <= 9'(NUM_PINS); // RL9
	assign commit_pin = txn_stop && state_q == plc_pkg::ST_PIN &&
		!rd_seen_q && blk_ok; // RL9
	assign commit_cyc = txn_stop && state_q == plc_pkg::ST_CYC &&
		!rd_seen_q && wr_cnt_q == plc_pkg::WORD_BYTES;

	// cyclic recording enable
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cyclic_log_en_q <= plc_pkg::CYCLIC_RST;
		end else if (commit_cyc) begin
			cyclic_log_en_q <= cyc_new_q; // RL1
		end
	end

	// refused block write pulse
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wr_reject_q <= 1'b0;
		end else begin
			wr_reject_q <= txn_stop && state_q == plc_pkg::ST_PIN &&
				!rd_seen_q && !blk_ok; // RL9
		end
	end

	////////////////////////////////////////////////////////////////////
	// per pin record and mode decode
	for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
		logic [7:0] off; // record slot for this pin
		logic       hit; // this pin lies in the written run
		assign off = 8'(p) - blk_idx_q;
		assign hit = {1'b0, blk_idx_q} <= 9'(p) && 9'(p) < blk_end;
		// record store
		always_ff @(posedge ref_clk) begin
			if (!rst_n) begin
				pin_rec_q[p] <= plc_pkg::PIN_REC_RST;
			end else if (commit_pin && hit) begin
				pin_rec_q[p] <= {stage_q[{off[3:0], 1'b1}],
					stage_q[{off[3:0], 1'b0}]}; // RL6 RL7
			end
		end
		// operating mode decode
		always_ff @(posedge ref_clk) begin
			if (!rst_n) begin
				pin_out_en_q[p] <= 1'b0;
				pin_in_en_q[p]  <= 1'b0;
			end else begin
				pin_out_en_q[p] <= pin_rec_q[p].mode == plc_pkg::MODE_OUT; // RL8
				pin_in_en_q[p]  <= pin_rec_q[p].mode == plc_pkg::MODE_IN;  // RL8
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// read answer select
	assign rd_off = rd_ptr_q - 6'h01;
	assign rd_pin = (blk_idx_q == plc_pkg::IDX_ALL ? 4'h0 : blk_idx_q[3:0])
		+ rd_off[4:1];
	always_comb begin
		if (blk_idx_q < plc_pkg::IDX_LIMIT) begin
			rd_len = plc_pkg::LEN_ONE; // RL4
		end else if (blk_idx_q == plc_pkg::IDX_ALL) begin
			rd_len = plc_pkg::LEN_ALL; // RL4
		end else begin
			rd_len = 8'h00; // unknown index returns nothing
		end
		rd_next = 8'h00;
		unique case (state_q)
			plc_pkg::ST_CYC: begin
				if (rd_ptr_q == 6'h00) begin
					rd_next = {7'h00, cyclic_log_en_q}; // RL1 RL10
				end
			end
			plc_pkg::ST_PIN: begin
				if (rd_ptr_q == 6'h00) begin
					rd_next = rd_len; // RL4
				end else if ({2'b00, rd_ptr_q} <= rd_len) begin
					rd_next = rd_off[0] ? pin_rec_q[rd_pin][15:8]
						: pin_rec_q[rd_pin][7:0]; // RL7
				end
			end
			default: begin
				rd_next = 8'h00; // other commands read zero
			end
		endcase
	end

	// read answer register
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_valid_q <= 1'b0;
			rd_data_q  <= 8'h00;
		end else begin
			rd_valid_q <= rd_req;
			if (rd_req) begin
				rd_data_q <= rd_next;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// assertions
	sequence s_cyc_commit;
		txn_stop && state_q == plc_pkg::ST_CYC && !rd_seen_q &&
			wr_cnt_q == plc_pkg::WORD_BYTES;
	endsequence
	sequence s_pin_commit;
		txn_stop && state_q == plc_pkg::ST_PIN && !rd_seen_q && blk_ok;
	endsequence
	sequence s_pin_refuse;
		txn_stop && state_q == plc_pkg::ST_PIN && !rd_seen_q && !blk_ok;
	endsequence

	cyc_commit_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL1
		s_cyc_commit |=> cyclic_log_en_q == $past(cyc_new_q))
		else $error("cyclic enable not taken from word write");
	cyc_reserved_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL10
		rd_req && state_q == plc_pkg::ST_CYC |=> rd_data_q[7:1] == 7'h00)
		else $error("reserved cyclic bits read nonzero");
	len_one_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL4
		rd_req && state_q == plc_pkg::ST_PIN && rd_ptr_q == 6'h00 &&
		blk_idx_q < plc_pkg::IDX_LIMIT |=> rd_data_q == 8'h02)
		else $error("single pin length is not two");
	len_all_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL4
		rd_req && state_q == plc_pkg::ST_PIN && rd_ptr_q == 6'h00 &&
		blk_idx_q == plc_pkg::IDX_ALL |=> rd_data_q == 8'h20)
		else $error("all pin length is not thirty two");
	rd_answer_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_req |=> rd_valid_q ##1 (rd_valid_q == $past(rd_req)))
		else $error("read answer not one cycle after request");
	count_range_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL5
		s_pin_commit |-> blk_cnt_q >= 8'h03 && blk_cnt_q <= 8'h21)
		else $error("block write taken with bad count");
	first_rec_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL6
		s_pin_commit |=> pin_rec_q[$past(blk_idx_q[3:0])] ==
		{$past(stage_q[1]), $past(stage_q[0])})
		else $error("first record not placed at start pin");
	refuse_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL9
		s_pin_refuse |=> wr_reject_q && $stable(pin_rec_q))
		else $error("refused write changed records");
	mode_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL8
		##1 pin_out_en_q[0] == ($past(pin_rec_q[0].mode) == 3'h1) &&
		pin_in_en_q[0] == ($past(pin_rec_q[0].mode) == 3'h2))
		else $error("pin mode decode wrong");
endmodule : plc_cmd

// ==== bench/plc_host.sv ====
`timescale 1ns/1ps
// host controller model: one strobe per call, launched off falling edges
module plc_host (
	input  wire logic ref_clk,   // core clock
	output logic      txn_start, // opens a transaction
	output logic [7:0] cmd_code, // command code
	output logic      wr_valid,  // data byte strobe
	output logic [7:0] wr_byte,  // data byte
	output logic      rd_req,    // read byte request
	output logic      txn_stop   // stop condition
);
	// idle bus at time zero
	initial {txn_start, cmd_code, wr_valid, wr_byte, rd_req, txn_stop} = '0;
	// s = {start, write, read, stop}; held one full cycle
	task automatic step(input logic [3:0] s, input logic [7:0] b);
		@(negedge ref_clk);
		{txn_start, wr_valid, rd_req, txn_stop} = s;
		cmd_code = b;
		wr_byte  = b;
		@(negedge ref_clk);
		{txn_start, wr_valid, rd_req, txn_stop} = 4'h0;
		cmd_code = ~b; // released lines carry no stale value
		wr_byte  = ~b;
	endtask : step
endmodule : plc_host

// ==== bench/tb.sv ====
`timescale 1ns/1ps
// self-checking bench: host model drives, integer model predicts
module tb;
	logic        ref_clk = 1'b0; // core clock
	logic        rst_n   = 1'b0; // sync reset
	logic        txn_start, wr_valid, rd_req, txn_stop; // strobes
	logic [7:0]  cmd_code, wr_byte, rd_data_q;          // bytes
	logic        rd_valid_q, cyclic_log_en_q, wr_reject_q; // flags
	logic [15:0] pin_out_en_q, pin_in_en_q;             // mode decode
	plc_pkg::plc_pin_rec_t [15:0] pin_rec_q;            // records
	int          failures     = 0; // mismatches
	int          total_checks = 0; // comparisons
	int          mdl_pin[16];      // model records
	int          mdl_cyc;          // model cyclic enable
	always #20 ref_clk = ~ref_clk; // 25 MHz
	plc_host u_host (.ref_clk, .txn_start, .cmd_code, .wr_valid, .wr_byte,
		.rd_req, .txn_stop);
	plc_cmd #(.NUM_PINS(16)) u_dut (.ref_clk, .rst_n, .txn_start,
		.cmd_code, .wr_valid, .wr_byte, .rd_req, .txn_stop, .rd_valid_q,
		.rd_data_q, .cyclic_log_en_q, .pin_rec_q, .pin_out_en_q,
		.pin_in_en_q, .wr_reject_q);
	////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	// one read byte, answered the cycle after the request
	task automatic rd(input int exp);
		u_host.step(4'h2, 8'h00);
		chk("rd_valid", 16'h1, {15'h0, rd_valid_q});
		chk("rd_byte", exp[15:0], {8'h00, rd_data_q});
	endtask : rd
	// all stored settings against the model
	task automatic chk_all();
		u_host.step(4'h0, 8'h00); // mode decode lags one more cycle
		chk("cyclic", mdl_cyc[15:0], {15'h0, cyclic_log_en_q});
		for (int p = 0; p < 16; p++) begin
			chk("rec", mdl_pin[p][15:0], pin_rec_q[p]);
			chk("out_en", 16'(mdl_pin[p][15:13] == 3'h1),
				{15'h0, pin_out_en_q[p]});
			chk("in_en", 16'(mdl_pin[p][15:13] == 3'h2),
				{15'h0, pin_in_en_q[p]});
		end
	endtask : chk_all
	// pin block write; model commits only a well formed block
	task automatic pwr(input int idx, input int n, input int cnt);
		int rec[$];
		bit ok;
		ok = cnt >= 3 && cnt <= 33 && cnt == 2 * n + 1 && idx < 16
			&& idx + n <= 16;
		u_host.step(4'h8, plc_pkg::CMD_PINS);
		u_host.step(4'h4, cnt[7:0]);
		u_host.step(4'h4, idx[7:0]);
		for (int i = 0; i < n; i++) begin
			rec.push_back(int'({3'(i % 8), 13'($urandom)}));
			u_host.step(4'h4, rec[i][7:0]);
			u_host.step(4'h4, rec[i][15:8]);
		end
		u_host.step(4'h1, 8'h00);
		chk("reject", 16'(!ok), {15'h0, wr_reject_q});
		if (ok) foreach (rec[i]) mdl_pin[idx + i] = rec[i];
		chk_all();
	endtask : pwr
	// pin write-read: length byte, then records low byte first
	task automatic prd(input int idx);
		int len;
		int b;
		len = idx == 255 ? 32 : (idx < 16 ? 2 : 0);
		b   = idx == 255 ? 0 : idx;
		u_host.step(4'h8, plc_pkg::CMD_PINS);
		u_host.step(4'h4, plc_pkg::PARAM_LEN);
		u_host.step(4'h4, idx[7:0]);
		rd(len);
		for (int i = 0; i < len; i++) begin
			rd(i % 2 ? mdl_pin[b + i / 2] >> 8 : mdl_pin[b + i / 2] % 256);
		end
		rd(0);
		u_host.step(4'h1, 8'h00);
		chk("reject", 16'h0, {15'h0, wr_reject_q});
	endtask : prd
	// unknown command and a short word write leave every setting alone
	task automatic ign();
		u_host.step(4'h8, 8'h5A);
		u_host.step(4'h4, 8'h01);
		rd(0);
		u_host.step(4'h1, 8'h00);
		u_host.step(4'h8, plc_pkg::CMD_CYCLIC);
		u_host.step(4'h4, ~mdl_cyc[7:0]);
		u_host.step(4'h1, 8'h00);
		chk_all();
	endtask : ign
	// cyclic word write then read back
	task automatic cyc(input logic [7:0] lo, input logic [7:0] hi);
		u_host.step(4'h8, plc_pkg::CMD_CYCLIC);
		u_host.step(4'h4, lo);
		u_host.step(4'h4, hi);
		u_host.step(4'h1, 8'h00);
		mdl_cyc = lo[0];
		chk("cyclic", mdl_cyc[15:0], {15'h0, cyclic_log_en_q});
		u_host.step(4'h8, plc_pkg::CMD_CYCLIC);
		rd(mdl_cyc);
		rd(0);
		u_host.step(4'h1, 8'h00);
	endtask : cyc
	// verdict and end of run
	task automatic end_of_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(58778));
		foreach (mdl_pin[p]) mdl_pin[p] = 0;
		mdl_cyc = 0;
		repeat (12) @(negedge ref_clk);
		rst_n = 1'b1;
		chk_all();
		$display("test reset done");
		cyc(8'hFF, 8'hFF);
		cyc(8'hFE, 8'h01);
		cyc(8'h01, 8'h00);
		$display("test cyclic done");
		pwr(0, 16, 33);
		pwr(15, 1, 3);
		for (int t = 0; t < 8; t++) begin
			int i;
			int n;
			i = $urandom % 16;
			n = 1 + $urandom % (16 - i);
			pwr(i, n, 2 * n + 1);
		end
		$display("test block write done");
		pwr(0, 0, 2);
		pwr(15, 2, 5);
		pwr(16, 1, 3);
		pwr(0, 1, 5);
		$display("test refusal done");
		ign();
		$display("test ignore done");
		prd(255);
		prd(15);
		prd(16);
		for (int t = 0; t < 4; t++) prd($urandom % 16);
		$display("test block read done");
		end_of_test();
	end
	// watchdog, far beyond the several hundred cycles expected
	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		$display("BAD watchdog exp done got hang");
		end_of_test();
	end
endmodule : tb
